/* File: hw/dcs_ctrl.sv */
// Memory controller end: spaces commands and clock-enable changes on the link.
// Behaviour
// RULE1: mode bit 10 chooses differential or single strobe.
// RULE2: read waits two cycles after a write.
// RULE3: clock enable counts after three equal samples.
// RULE4: clock enable held steady three cycles after change.
// RULE5: badly captured location rewritten before any read; a read of it two cycles after the write is still let through.
// RULE6: times become cycles, divided by period, rounded up.
// RULE7: activate allowed rounded precharge cycles after precharge.
// RULE8: auto-precharge write delay is recovery plus precharge.
// RULE9: cycle counts are actual clock edges.
// RULE10: activate allowed two cycles after power-down exit.
// RULE11: down-counters loaded on command, dependent blocked until zero.
`timescale 1ns/10ps
module dcs_ctrl (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire dcs_pkg::dcs_op_t CMD_OP,
  input wire logic [dcs_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [dcs_pkg::DATA_W-1:0] CMD_WDATA,
  input wire logic PD_REQ,
  output logic CMD_ACK,
  output logic [dcs_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic RD_CORRUPT,
  output logic CKE_STATE,
  output logic REWRITE_PEND,
  dcs_link_if.ctrl link
);
  import dcs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_DOWN = 2'h0,
    ST_WAKE = 2'h1,
    ST_RUN = 2'h2,
    ST_SLEEP = 2'h3
  } dcs_state_t;

  dcs_state_t state;
  dcs_state_t next_state;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] wtr_cnt;
  logic [CNT_W-1:0] rp_cnt;
  logic [CNT_W-1:0] dal_cnt;
  logic [CNT_W-1:0] xp_cnt;
  logic [MEM_DEPTH-1:0] stale;
  logic [MEM_AW-1:0] last_wr_loc;
  logic strobe_single;
  logic [MR_WR_W-1:0] wr_field;

  // ----------------------------------------------------------------
  // Request decode and spacing checks
  // ----------------------------------------------------------------
  wire logic [MEM_AW-1:0] req_loc = CMD_ADDR[MEM_AW-1:0];
  wire logic is_act = (CMD_OP == DCS_ACT);
  wire logic is_wr = (CMD_OP == DCS_WR) || (CMD_OP == DCS_WRA);
  wire logic is_rd = (CMD_OP == DCS_RD);
  wire logic is_mrs = (CMD_OP == DCS_MRS);
  wire logic hold_busy = (hold_cnt != '0);
  // Each spacing is a counter that must have run down to zero.
  wire logic act_ok = (rp_cnt == '0) && (dal_cnt == '0) && (xp_cnt == '0); // RULE7 RULE10 RULE11
  wire logic rd_ok = (wtr_cnt == '0) && !stale[req_loc]; // RULE2 RULE5 RULE11
  wire logic op_ok = is_act ? act_ok : (is_rd ? rd_ok : (CMD_OP != DCS_NOP));
  // The acknowledge cycle blocks a second take of the same held request.
  wire logic take = CMD_VALID && !CMD_ACK && (state == ST_RUN) && op_ok;
  wire logic want_sleep = PD_REQ && (state == ST_RUN) && !take && !CMD_VALID;
  wire logic want_wake = !PD_REQ && (state == ST_DOWN);
  // Commands already on the link drain before the clock enable drops.
  wire logic cke_change = (want_sleep || want_wake) && !hold_busy; // RULE4
  wire logic [CNT_W-1:0] dal_load = dcs_wr_cyc(wr_field) + dcs_load(PRECHARGE_CYC); // RULE8

  // ----------------------------------------------------------------
  // Power state sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_DOWN:
        if (cke_change)
          next_state = ST_WAKE;
      ST_WAKE:
        if (hold_cnt == 4'h1)
          next_state = ST_RUN;
      ST_RUN:
        if (cke_change)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (hold_cnt == 4'h1)
          next_state = ST_DOWN;
      default:
        next_state = ST_DOWN;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= ST_DOWN;
      link.cke <= 1'b0;
      CKE_STATE <= 1'b0;
      hold_cnt <= '0;
    end
    else if (CE)
    begin
      state <= next_state;
      if (cke_change)
      begin
        link.cke <= want_wake;
        CKE_STATE <= want_wake;
        // The far end needs the level on three edges in a row.
        hold_cnt <= CNT_W'(CKE_REG_CYC); // RULE3 RULE4
      end
      else if (hold_busy)
        hold_cnt <= hold_cnt - 1'b1; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Spacing counters
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wtr_cnt <= '0;
      rp_cnt <= '0;
      dal_cnt <= '0;
      xp_cnt <= '0;
    end
    else if (CE)
    begin
      if (take && is_wr)
        wtr_cnt <= dcs_load(WTR_CYC); // RULE2 RULE11
      else if (wtr_cnt != '0)
        wtr_cnt <= wtr_cnt - 1'b1;
      if (take && CMD_OP == DCS_PRE)
        rp_cnt <= dcs_load(PRECHARGE_CYC); // RULE6 RULE7
      else if (rp_cnt != '0)
        rp_cnt <= rp_cnt - 1'b1;
      // Only one bank is modelled, so the delay guards every activate.
      if (take && CMD_OP == DCS_WRA)
        dal_cnt <= dal_load; // RULE8 RULE11
      else if (dal_cnt != '0)
        dal_cnt <= dal_cnt - 1'b1;
      // The exit registers as the hold runs out; activate waits after that.
      if (state == ST_WAKE && hold_cnt == 4'h1)
        xp_cnt <= CNT_W'(PD_EXIT_CYC); // RULE10
      else if (xp_cnt != '0)
        xp_cnt <= xp_cnt - 1'b1; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Command drive, mode shadow and rewrite tracking
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      link.cmd <= DCS_NOP;
      link.addr <= '0;
      link.wdata <= '0;
      link.dqs <= 1'b0;
      // The default style is the pair, so the idle complement sits high.
      link.dqs_n <= 1'b1; // RULE1
      CMD_ACK <= 1'b0;
      strobe_single <= 1'b0;
      wr_field <= '0;
      last_wr_loc <= '0;
      stale <= '0;
      REWRITE_PEND <= 1'b0;
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
      RD_CORRUPT <= 1'b0;
    end
    else if (CE)
    begin
      CMD_ACK <= take;
      link.cmd <= take ? CMD_OP : DCS_NOP;
      link.addr <= take ? CMD_ADDR : '0;
      link.wdata <= (take && is_wr) ? CMD_WDATA : '0;
      link.dqs <= take && is_wr;
      // The complement pin only toggles when the pair is in use.
      link.dqs_n <= !strobe_single && !(take && is_wr); // RULE1
      if (take && is_mrs)
      begin
        strobe_single <= CMD_ADDR[STROBE_STYLE_SELECT_BIT]; // RULE1
        wr_field <= CMD_ADDR[MR_WR_LSB +: MR_WR_W];
      end
      if (take && is_wr)
        last_wr_loc <= req_loc;
      // A capture fault wins over a rewrite of the same place in that cycle.
      if (take && is_wr)
        stale[req_loc] <= 1'b0; // RULE5
      if (link.cap_err)
        stale[last_wr_loc] <= 1'b1; // RULE5
      REWRITE_PEND <= (stale != '0);
      RD_VALID <= link.rvalid;
      RD_DATA <= link.rdata;
      RD_CORRUPT <= link.rcorrupt;
    end
  end
endmodule : dcs_ctrl

/* File: hw/dcs_dram.sv */
// Memory device end: clock-enable registration, strobe capture and spacing checks.
`timescale 1ns/10ps
module dcs_dram (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  dcs_link_if.dram link,
  output logic TIMING_ERR,
  output logic POWER_DOWN,
  output logic STROBE_SINGLE,
  output logic CAPTURE_ERR
);
  import dcs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] corrupt;
  logic [CKE_REG_CYC-1:0] cke_hist;
  logic cke_reg;
  logic [CNT_W-1:0] rp_cnt;
  logic [CNT_W-1:0] xp_cnt;
  logic [CNT_W-1:0] dal_cnt;
  logic [MR_WR_W-1:0] wr_field;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [MEM_AW-1:0] loc = link.addr[MEM_AW-1:0];
  wire logic live = cke_reg;
  wire logic is_act = live && (link.cmd == DCS_ACT);
  wire logic is_wr = live && (link.cmd == DCS_WR || link.cmd == DCS_WRA);
  wire logic is_rd = live && (link.cmd == DCS_RD);
  wire logic is_pre = live && (link.cmd == DCS_PRE);
  wire logic is_mrs = live && (link.cmd == DCS_MRS);
  // Differential style needs the pair complementary; single style looks at one pin.
  wire logic strobe_ok = STROBE_SINGLE ? link.dqs : (link.dqs && !link.dqs_n); // RULE1
  // A new level counts only once three consecutive edges have all seen it.
  wire logic cke_settled = (cke_hist == {CKE_REG_CYC{~cke_reg}}); // RULE3
  wire logic pd_exit = cke_settled && !cke_reg;
  // Counters advance once per real clock edge, not per averaged period.
  wire logic act_early = is_act && (rp_cnt != '0 || xp_cnt != '0 || dal_cnt != '0); // RULE7 RULE9

  // ----------------------------------------------------------------
  // Clock enable registration and spacing counters
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cke_hist <= '0;
      cke_reg <= 1'b0;
      rp_cnt <= '0;
      xp_cnt <= '0;
      dal_cnt <= '0;
    end
    else if (CE)
    begin
      cke_hist <= {cke_hist[CKE_REG_CYC-2:0], link.cke}; // RULE3
      if (cke_settled)
        cke_reg <= ~cke_reg; // RULE3
      if (pd_exit)
        xp_cnt <= dcs_load(PD_EXIT_CYC); // RULE10
      else if (xp_cnt != '0)
        xp_cnt <= xp_cnt - 1'b1; // RULE9
      if (is_pre)
        rp_cnt <= dcs_load(int'(PRECHARGE_CYC)); // RULE7
      else if (rp_cnt != '0)
        rp_cnt <= rp_cnt - 1'b1;
      if (live && link.cmd == DCS_WRA)
        dal_cnt <= dcs_wr_cyc(wr_field) + dcs_load(PRECHARGE_CYC); // RULE8
      else if (dal_cnt != '0)
        dal_cnt <= dal_cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode, capture and read data
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      STROBE_SINGLE <= 1'b0;
      wr_field <= '0;
      corrupt <= '0;
      link.rdata <= '0;
      link.rvalid <= 1'b0;
      link.rcorrupt <= 1'b0;
      link.cap_err <= 1'b0;
      CAPTURE_ERR <= 1'b0;
      TIMING_ERR <= 1'b0;
      POWER_DOWN <= 1'b1;
    end
    else if (CE)
    begin
      POWER_DOWN <= cke_settled ? cke_reg : ~cke_reg;
      if (is_mrs)
      begin
        STROBE_SINGLE <= link.addr[STROBE_STYLE_SELECT_BIT]; // RULE1
        wr_field <= link.addr[MR_WR_LSB +: MR_WR_W];
      end
      // Data taken against a bad strobe is kept but marked unreliable.
      if (is_wr)
        corrupt[loc] <= !strobe_ok; // RULE1 RULE5
      link.cap_err <= is_wr && !strobe_ok;
      if (is_wr && !strobe_ok)
        CAPTURE_ERR <= 1'b1;
      link.rvalid <= is_rd;
      link.rdata <= is_rd ? mem[loc] : '0;
      link.rcorrupt <= is_rd && corrupt[loc]; // RULE5
      if (act_early)
        TIMING_ERR <= 1'b1; // RULE10
    end
  end

  // The array has no reset, as a real storage core would not.
  always_ff @(posedge CLK)
  begin
    if (CE && is_wr)
      mem[loc] <= link.wdata;
  end
endmodule : dcs_dram

/* File: include/dcs_link_if.sv */
// Link between the memory controller end and the memory device end.
`timescale 1ns/10ps
interface dcs_link_if;
  import dcs_pkg::*;

  logic cke;
  dcs_op_t cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic dqs;
  logic dqs_n;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic rcorrupt;
  logic cap_err;

  modport ctrl (
    output cke, cmd, addr, wdata, dqs, dqs_n,
    input rdata, rvalid, rcorrupt, cap_err
  );

  modport dram (
    input cke, cmd, addr, wdata, dqs, dqs_n,
    output rdata, rvalid, rcorrupt, cap_err
  );
endinterface : dcs_link_if

/* File: include/dcs_pkg.sv */
// Shared constants, command codes and helpers for the command spacing link.
package dcs_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Timing, with times in picoseconds and counts in clock cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int PRECHARGE_PS = 15000;
  // A time becomes cycles by dividing by the period and rounding up.
  localparam int PRECHARGE_CYC = (PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // RULE6
  localparam int WTR_CYC = 2;
  localparam int CKE_REG_CYC = 3;
  localparam int PD_EXIT_CYC = 2;

  // ----------------------------------------------------------------
  // Mode register fields carried on the address lines
  // ----------------------------------------------------------------
  localparam int STROBE_STYLE_SELECT_BIT = 10;
  localparam int MR_WR_LSB = 0;
  localparam int MR_WR_W = 3;
  localparam logic [CNT_W-1:0] WR_FIELD_OFFSET = 4'h1;

  typedef enum logic [2:0] {
    DCS_NOP = 3'h0,
    DCS_ACT = 3'h1,
    DCS_WR = 3'h2,
    DCS_WRA = 3'h3,
    DCS_RD = 3'h4,
    DCS_PRE = 3'h5,
    DCS_MRS = 3'h6
  } dcs_op_t;

  // Value a down-counter is loaded with so that the dependent command is
  // first seen exactly n edges after the initiating one.
  function automatic logic [CNT_W-1:0] dcs_load(input int n);
    dcs_load = (n > 1) ? CNT_W'(n - 1) : '0;
  endfunction : dcs_load

  // Write recovery in cycles from the mode register field.
  function automatic logic [CNT_W-1:0] dcs_wr_cyc(input logic [MR_WR_W-1:0] f);
    dcs_wr_cyc = CNT_W'(f) + WR_FIELD_OFFSET;
  endfunction : dcs_wr_cyc

endpackage : dcs_pkg

/* File: testbench/dcs_link_chk.sv */
// Concurrent checks on the link between the controller end and the device end.
`timescale 1ns/10ps
module dcs_link_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic cke,
  input wire dcs_pkg::dcs_op_t cmd,
  input wire logic [dcs_pkg::ADDR_W-1:0] addr,
  input wire logic [dcs_pkg::DATA_W-1:0] wdata,
  input wire logic dqs,
  input wire logic dqs_n,
  input wire logic [dcs_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic rcorrupt,
  input wire logic cap_err
);
  import dcs_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // --------------------------------------------------------------
  // Gap counters saturate, so an old command never looks recent.
  // --------------------------------------------------------------
  logic single_q;
  logic [3:0] wr_q;
  logic [4:0] pre_gap;
  logic [4:0] wra_gap;
  logic [3:0] up_cnt;
  logic [MEM_AW-1:0] wloc;
  logic [MEM_DEPTH-1:0] stale;
  wire is_wr = (cmd == DCS_WR) || (cmd == DCS_WRA);
  wire is_mrs = (cmd == DCS_MRS);

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      single_q <= 1'b0;
      wr_q <= 4'h1;
      pre_gap <= 5'h1F;
      wra_gap <= 5'h1F;
      up_cnt <= 4'h0;
      wloc <= '0;
      stale <= '0;
    end
    else
    begin
      pre_gap <= (cmd == DCS_PRE) ? 5'h01 : pre_gap + {4'h0, ~&pre_gap};
      wra_gap <= (cmd == DCS_WRA) ? 5'h01 : wra_gap + {4'h0, ~&wra_gap};
      up_cnt <= cke ? up_cnt + {3'h0, ~&up_cnt} : 4'h0;
      if (is_mrs)
      begin
        single_q <= addr[STROBE_STYLE_SELECT_BIT];
        wr_q <= {1'b0, addr[MR_WR_LSB +: MR_WR_W]} + 4'h1;
      end
      if (is_wr)
      begin
        wloc <= addr[MEM_AW-1:0];
        stale[addr[MEM_AW-1:0]] <= 1'b0;
      end
      if (cap_err)
        stale[wloc] <= 1'b1;
    end
  end

  a_strobe_on_write: assert property (dqs == is_wr)
    else $error("Strobe level differs from write command.");
  a_strobe_style: assert property (dqs_n == (!single_q && !dqs))
    else $error("Strobe pair does not match the selected style.");
  a_write_read_gap: assert property (is_wr |=> cmd != DCS_RD)
    else $error("Read follows a write too closely.");
  a_cke_steady: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("Clock enable moved inside its registration time.");
  a_act_after_exit: assert property (cmd == DCS_ACT |-> up_cnt >= 4)
    else $error("Activate too soon after clock enable rose.");
  a_pre_to_act: assert property (cmd == DCS_ACT |-> pre_gap >= PRECHARGE_CYC)
    else $error("Activate too soon after precharge.");
  a_dal_to_act: assert property (cmd == DCS_ACT |-> wra_gap >= wr_q + PRECHARGE_CYC)
    else $error("Activate too soon after auto-precharge write.");
  a_no_stale_read: assert property (cmd == DCS_RD |-> !stale[addr[MEM_AW-1:0]])
    else $error("Read of a location that still needs a rewrite.");
  a_read_clean: assert property (cmd == DCS_RD |=> rvalid && !rcorrupt)
    else $error("Read answer missing or corrupt.");

  cover property (is_wr ##2 cmd == DCS_RD);
  cover property (cmd == DCS_WRA ##[1:12] cmd == DCS_ACT);
  cover property ($fell(cke));
endmodule : dcs_link_chk

/* File: testbench/testbench.sv */
// Self-checking bench for both link ends, plus a device end driven by hand.
`timescale 1ns/10ps
module testbench;
  import dcs_pkg::*;
  typedef struct packed {dcs_op_t op; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;} dcs_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  dcs_op_t cmd_op = DCS_NOP;
  logic [ADDR_W-1:0] cmd_addr = 12'h000;
  logic [DATA_W-1:0] cmd_wdata = 8'h00;
  logic pd_req = 1'b0;
  logic cmd_ack, rd_valid, rd_corrupt, cke_state, rewrite_pend;
  logic [DATA_W-1:0] rd_data;
  logic t_err, p_down, s_single, c_err, b_terr, b_pd, b_cap;
  int err_count = 0;
  int checks = 0;
  dcs_row_t rows [11];
  dcs_link_if link_a ();
  dcs_link_if link_b ();

  always #20 clk = ~clk;

  dcs_ctrl i_dcs_ctrl (.CLK(clk), .RESETN(resetn), .CE(ce), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .PD_REQ(pd_req),
    .CMD_ACK(cmd_ack), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_CORRUPT(rd_corrupt),
    .CKE_STATE(cke_state), .REWRITE_PEND(rewrite_pend), .link(link_a));
  dcs_dram i_dcs_dram (.CLK(clk), .RESETN(resetn), .CE(ce), .link(link_a),
    .TIMING_ERR(t_err), .POWER_DOWN(p_down), .STROBE_SINGLE(s_single), .CAPTURE_ERR(c_err));
  // The second device end faces the bench, which breaks the link rules on purpose.
  dcs_dram i_dcs_dram_b (.CLK(clk), .RESETN(resetn), .CE(ce), .link(link_b),
    .TIMING_ERR(b_terr), .POWER_DOWN(b_pd), .STROBE_SINGLE(), .CAPTURE_ERR(b_cap));
  dcs_link_chk i_dcs_link_chk (.CLK(clk), .RESETN(resetn), .cke(link_a.cke),
    .cmd(link_a.cmd), .addr(link_a.addr), .wdata(link_a.wdata), .dqs(link_a.dqs),
    .dqs_n(link_a.dqs_n), .rdata(link_a.rdata), .rvalid(link_a.rvalid),
    .rcorrupt(link_a.rcorrupt), .cap_err(link_a.cap_err));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic conclude();
    $display("Mismatches %0d in %0d comparisons", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 300)
      begin
        err_count++;
        conclude();
      end
    end
  endtask : wait_hi

  task automatic issue(input dcs_row_t r);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = r.op;
    cmd_addr = r.addr;
    cmd_wdata = r.data;
    @(negedge clk);
    wait_hi(cmd_ack);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic bset(input logic k, input dcs_op_t op, input logic [11:0] a, input logic [1:0] s);
    link_b.cke = k;
    link_b.cmd = op;
    link_b.addr = a;
    link_b.wdata = 8'h77;
    link_b.dqs = s[1];
    link_b.dqs_n = s[0];
  endtask : bset

  task automatic bcyc(input logic k, input dcs_op_t op, input logic [11:0] a, input logic [1:0] s);
    @(negedge clk);
    bset(k, op, a, s);
  endtask : bcyc

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    bset(1'b0, DCS_NOP, 12'h000, 2'b01);
    rows = '{'{DCS_MRS, 12'h001, 8'h00}, '{DCS_WR, 12'h003, 8'hA5}, '{DCS_RD, 12'h003, 8'hA5},
      '{DCS_PRE, 12'h000, 8'h00}, '{DCS_ACT, 12'h000, 8'h00}, '{DCS_WRA, 12'h004, 8'h3C},
      '{DCS_ACT, 12'h000, 8'h00}, '{DCS_RD, 12'h004, 8'h3C}, '{DCS_MRS, 12'h400, 8'h00},
      '{DCS_WR, 12'h00F, 8'h5A}, '{DCS_RD, 12'h00F, 8'h5A}};
    repeat (6) @(negedge clk);
    chk(p_down, 1'b1);
    chk(cke_state, 1'b0);
    chk(16'(PRECHARGE_CYC), 16'h0001);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      issue(rows[i]);
      if (rows[i].op == DCS_RD)
      begin
        wait_hi(rd_valid);
        chk(rd_data, rows[i].data);
        chk(rd_corrupt, 1'b0);
      end
    end
    chk(s_single, 1'b1);
    chk(t_err, 1'b0);
    chk(c_err, 1'b0);
    chk(rewrite_pend, 1'b0);
    pd_req = 1'b1;
    wait_hi(p_down);
    chk(cke_state, 1'b0);
    pd_req = 1'b0;
    issue(dcs_row_t'{DCS_ACT, 12'h000, 8'h00});
    chk(p_down, 1'b0);
    chk(t_err, 1'b0);
    // A two-cycle clock-enable pulse must not wake the device.
    repeat (2) bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    repeat (4) bcyc(1'b0, DCS_NOP, 12'h000, 2'b01);
    chk(b_pd, 1'b1);
    repeat (6) bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk(b_pd, 1'b0);
    bcyc(1'b1, DCS_MRS, 12'h001, 2'b01);
    bcyc(1'b1, DCS_WR, 12'h002, 2'b11);
    repeat (2) bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk(b_cap, 1'b1);
    bcyc(1'b1, DCS_RD, 12'h002, 2'b01);
    bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk({link_b.rvalid, link_b.rcorrupt, link_b.rdata}, 16'h0377);
    bcyc(1'b1, DCS_WR, 12'h002, 2'b10);
    bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    bcyc(1'b1, DCS_RD, 12'h002, 2'b01);
    bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk({link_b.rvalid, link_b.rcorrupt}, 16'h0002);
    bcyc(1'b1, DCS_PRE, 12'h000, 2'b01);
    bcyc(1'b1, DCS_ACT, 12'h000, 2'b01);
    bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk(b_terr, 1'b0);
    bcyc(1'b1, DCS_WRA, 12'h005, 2'b10);
    bcyc(1'b1, DCS_ACT, 12'h000, 2'b01);
    repeat (2) bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk(b_terr, 1'b1);
    // With ce low a read must leave no answer behind, though the link clock enable stays high.
    ce = 1'b0;
    bcyc(1'b1, DCS_RD, 12'h002, 2'b01);
    bcyc(1'b1, DCS_NOP, 12'h000, 2'b01);
    chk(link_b.rvalid, 1'b0);
    chk(b_terr, 1'b1);
    conclude();
  end
endmodule : testbench
